// ==== src/fpec_pkg.sv ====
package fpec_pkg;

    // Clock and timing.
    localparam int CLK_MHZ = 40;
    localparam int UNLOCK_WAIT_US = 10;
    localparam int UNLOCK_WAIT_CYC = UNLOCK_WAIT_US * CLK_MHZ;
    localparam int VERIFY_WAIT_US = 4;
    localparam int VERIFY_WAIT_CYC = VERIFY_WAIT_US * CLK_MHZ;
    localparam int PROG_TIME_US = 100;
    localparam int PROG_CYC = PROG_TIME_US * CLK_MHZ;
    localparam int ERASE_PULSE_MS = 250;
    localparam int ERASE_PULSE_CYC = ERASE_PULSE_MS * 1000 * CLK_MHZ;

    // Unlock pointer value and the address that the second unlock write must hit.
    localparam logic [15:0] UNLOCK_PTR = 16'h4000;
    localparam logic [16:0] UNLOCK_ADDR = 17'h04000;

    // Bank layout in 16-bit words: 48K, 48K, 24K, 8K bytes.
    localparam logic [15:0] BANK_BASE [4] = '{16'h0000, 16'h6000, 16'hC000, 16'hF000};
    localparam logic [15:0] BANK_LAST [4] = '{16'h5FFF, 16'hBFFF, 16'hEFFF, 16'hFFFF};
    localparam logic [5:0] BANK_PULSES [4] = '{6'h2C, 6'h2C, 6'h16, 6'h04};

    // Control/status word layout.
    localparam int FCR_WIDTH = 16;
    localparam int B_WRITE_EN = 0;
    localparam int B_ERASE_EN = 1;
    localparam int B_BUSY = 2;
    localparam int B_READ_PROT = 3;
    localparam int B_VPP_FLAG = 4;
    localparam int B_VPP_REVEAL = 5;
    localparam int B_TIMER_CLK = 6;
    localparam int B_DOUBLE_WORD = 7;
    localparam int B_BANK_LO = 8;
    localparam int B_BANK_HI = 9;
    localparam int B_WRITE_MODE = 10;
    localparam logic [10:0] CTL_RST = 11'h000;
    localparam logic [10:0] CTL_WR_MASK = 11'h3EB;
    localparam logic [15:0] ALL_ONES = 16'hFFFF;

    typedef enum logic [2:0] {
        ST_NORMAL = 3'b000,
        ST_ARMED = 3'b001,
        ST_OPENING = 3'b010,
        ST_WMODE = 3'b011,
        ST_PROG = 3'b100,
        ST_ERASE = 3'b101,
        ST_FILL = 3'b110
    } fpec_state_t;

endpackage

// ==== src/fpec_array.sv ====
`timescale 1ns/100ps
module fpec_array (
    // Clock.
    input wire logic clk_in,
    // Read port, one cycle latency.
    input wire logic rd_in,
    input wire logic [15:0] raddr_in,
    output logic [15:0] rdata_out,
    // Write port.
    input wire logic we_in,
    input wire logic [15:0] waddr_in,
    input wire logic [15:0] wdata_in
);
    logic [15:0] mem [65536];

    // No reset: array contents are nonvolatile and only the sequencer changes them.
    always_ff @(posedge clk_in) begin
        if (we_in) begin
            mem[waddr_in] <= wdata_in;
        end
        if (rd_in) begin
            rdata_out <= mem[raddr_in];
        end
    end
endmodule

// ==== src/fpec_top.sv ====
// Functional notes
// R1 - Flash holds four banks of 48K, 48K, 24K and 8K bytes, in order.
// R2 - A completed bank erase leaves every bit of that bank at one.
// R3 - Control word holds eleven bits of control and status.
// R4 - A two-bit bank field picks the bank that an erase targets.
// R5 - Control word has no address; it shows only during writing mode.
// R6 - Two-write unlock sequence with pointer value 4000 enters writing mode.
// R7 - From 10 us after unlock, even-address reads return the control word.
// R8 - A key write anywhere in flash leaves writing mode.
// R9 - Core erases by unlock, configure, zero-program, then key write.
// R10 - Core's erase key pointer uses data page 5, any bank.
// R11 - Verify is two reads of one location 4 us apart; ones expected.
// R12 - Core verifies every programmed record the same way.
// R13 - Erase time varies with pulse count, about 1 s to 11 s.
// R14 - Word mode programs one word at the written address.
// R15 - Double-word mode programs two words from two writes to one address.
// R16 - Core programs only erased banks.
// R17 - Loader types records 0 data, 2 extended address, 4 code.
// R18 - Host sends 32-byte records, each programmed and verified.
// R19 - Busy holds from operation start until its pulse completes.
`timescale 1ns/100ps
module fpec_top #(
    parameter int ERASE_PULSE_CYC = fpec_pkg::ERASE_PULSE_CYC
) (
    // Clock, reset and clock enable.
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic ce_in,
    // Core access to the flash address space (byte address, word data).
    input wire logic mem_rd_in,
    input wire logic mem_wr_in,
    input wire logic [16:0] mem_addr_in,
    input wire logic [15:0] mem_wdata_in,
    output logic [15:0] mem_rdata_out,
    output logic mem_rvalid_out,
    // Programming voltage and status.
    input wire logic vpp_present_in,
    output logic write_mode_out,
    output logic busy_out,
    output logic verify_pass_out
);
    typedef struct packed {
        fpec_pkg::fpec_state_t st;
        logic [10:0] ctl;
        logic [23:0] cnt;
        logic [5:0] pulses;
        logic [15:0] waddr;
        logic [15:0] d0;
        logic [15:0] d1;
        logic dbl;
        logic have_first;
        logic pend;
        logic pend_fcr;
        logic pend_vfy;
        logic [15:0] last_addr;
        logic [7:0] vgap;
        logic [15:0] rdata;
        logic rvalid;
        logic vpass;
    } fpec_regs_t;

    fpec_regs_t s_ff;
    fpec_regs_t nxt_s;
    logic [15:0] arr_q;
    logic arr_we;
    logic [15:0] arr_waddr;
    logic [15:0] arr_wdata;
    logic [15:0] fcr_word;
    logic [1:0] bank;
    logic [15:0] widx;
    logic rd_go;
    logic wr_go;

    ////////////////////////////////////////////////////////////////////////////
    assign bank = s_ff.ctl[fpec_pkg::B_BANK_HI:fpec_pkg::B_BANK_LO];
    assign widx = mem_addr_in[16:1];
    assign rd_go = ce_in && mem_rd_in;
    assign wr_go = ce_in && mem_wr_in;

    always_comb begin
        fcr_word = 16'h0000;
        fcr_word[10:0] = s_ff.ctl & fpec_pkg::CTL_WR_MASK; // [R3]
        fcr_word[fpec_pkg::B_BUSY] = busy_out;
        fcr_word[fpec_pkg::B_VPP_FLAG] = s_ff.ctl[fpec_pkg::B_VPP_REVEAL] && vpp_present_in;
        fcr_word[fpec_pkg::B_WRITE_MODE] = 1'b1;
    end

    always_comb begin
        nxt_s = s_ff;
        arr_we = 1'b0;
        arr_waddr = s_ff.waddr;
        arr_wdata = s_ff.d0;
        nxt_s.rvalid = 1'b0;
        nxt_s.vpass = 1'b0;
        if (s_ff.vgap != 8'(fpec_pkg::VERIFY_WAIT_CYC)) begin
            nxt_s.vgap = s_ff.vgap + 8'h01;
        end
        // Read path: array data, or the control word on an even address once open.
        if (s_ff.pend) begin
            nxt_s.pend = 1'b0;
            nxt_s.rvalid = 1'b1;
            nxt_s.rdata = s_ff.pend_fcr ? fcr_word : arr_q; // [R5] [R7]
            nxt_s.vpass = s_ff.pend_vfy && !s_ff.pend_fcr && (arr_q == fpec_pkg::ALL_ONES); // [R11]
        end
        if (rd_go) begin
            nxt_s.pend = 1'b1;
            nxt_s.pend_fcr = (s_ff.st == fpec_pkg::ST_WMODE) && !mem_addr_in[0]; // [R5] [R7]
            // A second read of one location after the wait counts as a verify read.
            nxt_s.pend_vfy = (widx == s_ff.last_addr) && (s_ff.vgap == 8'(fpec_pkg::VERIFY_WAIT_CYC)); // [R11]
            nxt_s.last_addr = widx;
            nxt_s.vgap = 8'h00;
        end
        unique case (s_ff.st)
            fpec_pkg::ST_NORMAL: begin
                if (wr_go && mem_wdata_in == fpec_pkg::UNLOCK_PTR) begin
                    nxt_s.st = fpec_pkg::ST_ARMED; // [R6]
                end
            end
            fpec_pkg::ST_ARMED: begin
                if (wr_go) begin
                    if (mem_addr_in == fpec_pkg::UNLOCK_ADDR && mem_wdata_in == fpec_pkg::UNLOCK_PTR) begin
                        nxt_s.st = fpec_pkg::ST_OPENING; // [R6]
                        nxt_s.cnt = 24'h000000;
                    end else begin
                        nxt_s.st = fpec_pkg::ST_NORMAL;
                    end
                end
            end
            fpec_pkg::ST_OPENING: begin
                // Writes here are dropped: the core must wait before touching the word.
                if (s_ff.cnt == 24'(fpec_pkg::UNLOCK_WAIT_CYC - 1)) begin
                    nxt_s.st = fpec_pkg::ST_WMODE; // [R7]
                    nxt_s.have_first = 1'b0;
                end else begin
                    nxt_s.cnt = s_ff.cnt + 24'h000001;
                end
            end
            fpec_pkg::ST_WMODE: begin
                if (wr_go) begin
                    if (s_ff.ctl[fpec_pkg::B_ERASE_EN] && vpp_present_in) begin
                        nxt_s.st = fpec_pkg::ST_ERASE; // [R8] [R19]
                        // The erase enable clears once the erase starts, so a later configure write cannot start a stray erase.
                        nxt_s.ctl[fpec_pkg::B_ERASE_EN] = 1'b0;
                        nxt_s.pulses = fpec_pkg::BANK_PULSES[bank]; // [R4] [R13]
                        nxt_s.cnt = 24'h000000;
                    end else if (s_ff.ctl[fpec_pkg::B_WRITE_EN] && vpp_present_in) begin
                        if (s_ff.ctl[fpec_pkg::B_DOUBLE_WORD] && !widx[0] && !s_ff.have_first) begin
                            nxt_s.have_first = 1'b1; // [R15]
                            nxt_s.d0 = mem_wdata_in;
                            nxt_s.waddr = widx;
                        end else begin
                            nxt_s.st = fpec_pkg::ST_PROG; // [R14] [R19]
                            nxt_s.ctl[fpec_pkg::B_WRITE_EN] = 1'b0;
                            nxt_s.cnt = 24'h000000;
                            nxt_s.dbl = s_ff.have_first && widx == s_ff.waddr; // [R15]
                            nxt_s.d0 = s_ff.have_first ? s_ff.d0 : mem_wdata_in;
                            nxt_s.d1 = mem_wdata_in;
                            nxt_s.waddr = s_ff.have_first ? s_ff.waddr : widx;
                        end
                    end else if (mem_wdata_in[fpec_pkg::B_WRITE_MODE]) begin
                        nxt_s.ctl = mem_wdata_in[10:0] & fpec_pkg::CTL_WR_MASK; // [R3] [R4]
                    end else begin
                        nxt_s.st = fpec_pkg::ST_NORMAL; // [R8]
                    end
                end
            end
            fpec_pkg::ST_PROG: begin
                if (ce_in) begin
                    if (s_ff.cnt == 24'(fpec_pkg::PROG_CYC - 1)) begin
                        arr_we = 1'b1; // [R14]
                        if (s_ff.dbl) begin
                            // Second word follows at once; the pulse covered both.
                            nxt_s.dbl = 1'b0; // [R15]
                            nxt_s.waddr = s_ff.waddr + 16'h0001;
                            nxt_s.d0 = s_ff.d1;
                        end else begin
                            nxt_s.st = fpec_pkg::ST_NORMAL; // [R19]
                            nxt_s.have_first = 1'b0;
                        end
                    end else begin
                        nxt_s.cnt = s_ff.cnt + 24'h000001;
                    end
                end
            end
            fpec_pkg::ST_ERASE: begin
                if (ce_in) begin
                    if (s_ff.cnt == 24'(ERASE_PULSE_CYC - 1)) begin
                        nxt_s.cnt = 24'h000000;
                        nxt_s.pulses = s_ff.pulses - 6'h01; // [R13]
                        if (s_ff.pulses == 6'h01) begin
                            nxt_s.st = fpec_pkg::ST_FILL;
                            nxt_s.waddr = fpec_pkg::BANK_BASE[bank]; // [R1]
                        end
                    end else begin
                        nxt_s.cnt = s_ff.cnt + 24'h000001;
                    end
                end
            end
            fpec_pkg::ST_FILL: begin
                if (ce_in) begin
                    arr_we = 1'b1;
                    arr_wdata = fpec_pkg::ALL_ONES; // [R2]
                    nxt_s.waddr = s_ff.waddr + 16'h0001;
                    if (s_ff.waddr == fpec_pkg::BANK_LAST[bank]) begin
                        nxt_s.st = fpec_pkg::ST_NORMAL; // [R1] [R19]
                    end
                end
            end
            default: begin
                nxt_s.st = fpec_pkg::ST_NORMAL;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            s_ff <= '{st: fpec_pkg::ST_NORMAL, ctl: fpec_pkg::CTL_RST, default: '0};
        end else if (ce_in) begin
            s_ff <= nxt_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    fpec_array u_array (
        .clk_in(clk_in),
        .rd_in(rd_go),
        .raddr_in(widx),
        .rdata_out(arr_q),
        .we_in(arr_we),
        .waddr_in(arr_waddr),
        .wdata_in(arr_wdata)
    );

    assign mem_rdata_out = s_ff.rdata;
    assign mem_rvalid_out = s_ff.rvalid;
    assign verify_pass_out = s_ff.vpass;
    assign write_mode_out = (s_ff.st == fpec_pkg::ST_OPENING) || (s_ff.st == fpec_pkg::ST_WMODE);
    assign busy_out = (s_ff.st == fpec_pkg::ST_PROG) || (s_ff.st == fpec_pkg::ST_ERASE) ||
        (s_ff.st == fpec_pkg::ST_FILL); // [R19]

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rstn_in);

    a_fcr_hidden_normal: assert property ((s_ff.st != fpec_pkg::ST_WMODE) && rd_go |=> !s_ff.pend_fcr) // [R5]
        else $error("control word exposed outside writing mode");
    a_unlock_opens: assert property ((s_ff.st == fpec_pkg::ST_ARMED) && wr_go && mem_addr_in == fpec_pkg::UNLOCK_ADDR
        && mem_wdata_in == fpec_pkg::UNLOCK_PTR |=> write_mode_out && s_ff.cnt == 24'h000000) // [R6]
        else $error("unlock sequence not recognised");
    a_open_wait_len: assert property ($rose(s_ff.st == fpec_pkg::ST_WMODE) |->
        $past(s_ff.cnt) == 24'(fpec_pkg::UNLOCK_WAIT_CYC - 1)) // [R7]
        else $error("writing mode opened before the unlock wait");
    a_key_exit: assert property ((s_ff.st == fpec_pkg::ST_WMODE) && wr_go && !mem_wdata_in[fpec_pkg::B_WRITE_MODE]
        && !s_ff.ctl[fpec_pkg::B_WRITE_EN] && !s_ff.ctl[fpec_pkg::B_ERASE_EN] |=> !write_mode_out) // [R8]
        else $error("key write did not leave writing mode");
    a_erase_start: assert property ((s_ff.st == fpec_pkg::ST_WMODE) && wr_go && s_ff.ctl[fpec_pkg::B_ERASE_EN]
        && vpp_present_in |=> busy_out && s_ff.pulses == fpec_pkg::BANK_PULSES[bank]) // [R13]
        else $error("erase did not start with bank pulse count");
    a_fill_ones: assert property ((s_ff.st == fpec_pkg::ST_FILL) && ce_in |->
        arr_we && arr_wdata == fpec_pkg::ALL_ONES) // [R2]
        else $error("erase fill not all ones");
    a_fill_in_bank: assert property ((s_ff.st == fpec_pkg::ST_FILL) |->
        s_ff.waddr >= fpec_pkg::BANK_BASE[bank] && s_ff.waddr <= fpec_pkg::BANK_LAST[bank]) // [R1]
        else $error("erase fill outside selected bank");
    a_dbl_second: assert property ((s_ff.st == fpec_pkg::ST_PROG) && arr_we && s_ff.dbl |=>
        (s_ff.st == fpec_pkg::ST_PROG) && arr_we && s_ff.waddr == $past(s_ff.waddr) + 16'h0001) // [R15]
        else $error("second word of double write missing");
    a_fcr_layout: assert property (s_ff.pend && s_ff.pend_fcr |=>
        mem_rvalid_out && mem_rdata_out[15:11] == 5'h00 && mem_rdata_out[fpec_pkg::B_WRITE_MODE]) // [R3]
        else $error("control word layout wrong");
    a_verify_ones: assert property (verify_pass_out |-> mem_rvalid_out && mem_rdata_out == fpec_pkg::ALL_ONES) // [R11]
        else $error("verify pass without all ones");
    a_busy_hold: assert property ($rose(busy_out) |-> busy_out [*8]) // [R19]
        else $error("busy dropped early");
endmodule

// ==== dv/fpec_core_model.sv ====
`timescale 1ns/100ps
module fpec_core_model (
    // Clock.
    input wire logic clk_in,
    // Flash space access.
    output logic mem_rd_out,
    output logic mem_wr_out,
    output logic [16:0] mem_addr_out,
    output logic [15:0] mem_wdata_out,
    input wire logic [15:0] mem_rdata_in,
    input wire logic mem_rvalid_in,
    input wire logic verify_pass_in
);
    initial begin
        mem_rd_out = 1'b0;
        mem_wr_out = 1'b0;
        mem_addr_out = 17'h00000;
        mem_wdata_out = 16'h0000;
    end

    task automatic waitc(input int n);
        repeat (n) @(negedge clk_in);
    endtask

    // A released data bus shows the inverse, so a stale value cannot pass for a fresh one.
    task automatic wr(input logic [16:0] a, input logic [15:0] w);
        @(negedge clk_in);
        mem_wr_out = 1'b1;
        mem_addr_out = a;
        mem_wdata_out = w;
        @(negedge clk_in);
        mem_wr_out = 1'b0;
        mem_wdata_out = ~w;
    endtask

    task automatic rd(input logic [16:0] a, output logic [15:0] d, output logic p);
        @(negedge clk_in);
        mem_rd_out = 1'b1;
        mem_addr_out = a;
        @(negedge clk_in);
        mem_rd_out = 1'b0;
        for (int i = 0; i < 4 && mem_rvalid_in !== 1'b1; i++) begin
            @(negedge clk_in);
        end
        d = (mem_rvalid_in === 1'b1) ? mem_rdata_in : 16'hXXXX;
        p = verify_pass_in & mem_rvalid_in;
    endtask

    task automatic unlock();
        wr(17'h1E000, fpec_pkg::UNLOCK_PTR);
        wr(fpec_pkg::UNLOCK_ADDR, fpec_pkg::UNLOCK_PTR);
    endtask

    // Two reads of one word with the settling wait between and nothing else in between.
    task automatic vfy(input logic [16:0] a, output logic [15:0] d, output logic p);
        rd(a, d, p);
        waitc(fpec_pkg::VERIFY_WAIT_CYC);
        rd(a, d, p);
    endtask
endmodule

// ==== dv/tb_flash_program_erase_control.sv ====
`timescale 1ns/100ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
    $display("ERROR %0t mismatch got %h exp %h", $time, (g), (e)); end end
module tb_flash_program_erase_control;
    localparam int PULSE = 10;
    logic clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic ce_in = 1'b1;
    logic vpp_present_in = 1'b1;
    logic mem_rd, mem_wr, write_mode_out, busy_out, verify_pass_out, mem_rvalid_out;
    logic [16:0] mem_addr;
    logic [15:0] mem_wdata, mem_rdata_out, d, w;
    logic p;
    int n_errors = 0;
    int cmp_count = 0;
    int cyc = 0;
    int n;

    always #12.5 clk_in = ~clk_in;

    fpec_top #(.ERASE_PULSE_CYC(PULSE)) dut_u (.clk_in(clk_in), .rstn_in(rstn_in), .ce_in(ce_in),
        .mem_rd_in(mem_rd), .mem_wr_in(mem_wr), .mem_addr_in(mem_addr), .mem_wdata_in(mem_wdata),
        .mem_rdata_out(mem_rdata_out), .mem_rvalid_out(mem_rvalid_out), .vpp_present_in(vpp_present_in),
        .write_mode_out(write_mode_out), .busy_out(busy_out), .verify_pass_out(verify_pass_out));

    fpec_core_model core_u (.clk_in(clk_in), .mem_rd_out(mem_rd), .mem_wr_out(mem_wr),
        .mem_addr_out(mem_addr), .mem_wdata_out(mem_wdata), .mem_rdata_in(mem_rdata_out),
        .mem_rvalid_in(mem_rvalid_out), .verify_pass_in(verify_pass_out));

    task automatic final_report();
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Writing a setting that is already loaded is skipped, because a write with an
    // enable still set would start an operation instead of reconfiguring.
    task automatic open_cfg(input logic [15:0] cfg);
        core_u.unlock();
        core_u.waitc(1);
        `CHK(write_mode_out, 1'b1)
        core_u.waitc(fpec_pkg::UNLOCK_WAIT_CYC);
        core_u.rd(17'h1E000, d, p);
        `CHK(d[10], 1'b1)
        if ((d[10:0] & fpec_pkg::CTL_WR_MASK) !== (cfg[10:0] & fpec_pkg::CTL_WR_MASK)) begin
            core_u.wr(17'h1E000, cfg);
        end
    endtask

    task automatic op(input logic [16:0] a, input logic [15:0] v, output int cnt);
        core_u.wr(a, v);
        cnt = 0;
        for (int i = 0; i < 4 && busy_out !== 1'b1; i++) begin
            core_u.waitc(1);
        end
        `CHK(busy_out, 1'b1)
        while (busy_out === 1'b1 && cnt < 10000) begin
            cnt++;
            core_u.waitc(1);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 70000) begin
            n_errors++;
            final_report();
        end
    end

    initial begin
        repeat (2) @(posedge clk_in);
        @(negedge clk_in);
        rstn_in = 1'b1;
        `CHK(busy_out, 1'b0)
        `CHK(write_mode_out, 1'b0)
        open_cfg(16'h0721);
        `CHK(d, 16'h0400)
        // One zeroed word stands for the zero pass; the erase must overwrite it.
        op(17'h1E000, 16'h0000, n);
        core_u.rd(17'h1E000, d, p);
        `CHK(d, 16'h0000)
        open_cfg(16'h0722);
        core_u.rd(17'h1E004, d, p);
        `CHK(d, 16'h0732)
        op(17'h14000, 16'h0000, n);
        `CHK(n >= 4 * PULSE + 4092 && n <= 4 * PULSE + 4100, 1'b1)
        `CHK(write_mode_out, 1'b0)
        core_u.rd(17'h1E000, d, p);
        `CHK(d, 16'hFFFF)
        core_u.rd(17'h1FFFE, d, p);
        `CHK(d, 16'hFFFF)
        // One 32-byte record written as eight double-word pairs into the erased bank.
        for (int k = 0; k < 8; k++) begin
            open_cfg(16'h04A1);
            w = 16'h1200 + 16'(2 * k);
            core_u.wr(17'h1E040 + 17'(4 * k), w);
            op(17'h1E040 + 17'(4 * k), w + 16'h0001, n);
            `CHK(n >= fpec_pkg::PROG_CYC - 4 && n <= fpec_pkg::PROG_CYC + 4, 1'b1)
        end
        for (int j = 0; j < 16; j++) begin
            core_u.vfy(17'h1E040 + 17'(2 * j), d, p);
            `CHK(d, 16'h1200 + 16'(j))
            `CHK(p, 1'b0)
        end
        core_u.vfy(17'h1E060, d, p);
        `CHK(d, 16'hFFFF)
        `CHK(p, 1'b1)
        open_cfg(16'h0421);
        op(17'h1E080, 16'h00C3, n);
        `CHK(n >= fpec_pkg::PROG_CYC - 4 && n <= fpec_pkg::PROG_CYC + 4, 1'b1)
        core_u.rd(17'h1E080, d, p);
        `CHK(d, 16'h00C3)
        core_u.rd(17'h1E082, d, p);
        `CHK(d, 16'hFFFF)
        vpp_present_in = 1'b0;
        core_u.unlock();
        core_u.waitc(fpec_pkg::UNLOCK_WAIT_CYC + 1);
        core_u.rd(17'h1E000, d, p);
        `CHK(d, 16'h0420)
        core_u.wr(17'h1E000, 16'h0000);
        core_u.waitc(2);
        `CHK(write_mode_out, 1'b0)
        `CHK(busy_out, 1'b0)
        core_u.rd(17'h1E000, d, p);
        `CHK(d, 16'hFFFF)
        final_report();
    end
endmodule
